// ---- common/cicd_pkg.sv ----
// Purpose: Shared constants and carriers for the integrator-comb decimator
// Assumes: One clock domain, APB register access with 32-bit data
// Notes:   Integrator words are kept MSB aligned on a 69-bit bus
package cicd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Data path widths
    localparam int CICD_SAMPLE_W      = 24;   // Mixer sample and output width
    localparam int CICD_BUS_W         = 69;   // Extended bus, first integrator
    localparam int CICD_MAX_STAGES    = 5;    // Most integrator/comb pairs
    localparam int CICD_COMB_W        = 24;   // Every comb stage width
    localparam int CICD_SHIFT_W       = 6;    // Programmed shift code width
    localparam int CICD_MAX_SHIFT     = 47;   // Largest barrel shifter step
    localparam int CICD_EXP_W         = 3;    // Floating-point input exponent
    localparam int CICD_RANGE_W       = 3;    // Range-control exponent bits
    localparam int CICD_TOTAL_SHIFT_W = 7;    // Shift code plus both exponents
    localparam int CICD_COUNT_W       = 16;   // Output sample counter width

    // Integrator widths, stage one first
    localparam int CICD_INT_W [CICD_MAX_STAGES] = '{69, 62, 53, 44, 34};

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] CICD_CTRL_OFS   = 8'h00;
    localparam logic [7:0] CICD_DECIM_OFS  = 8'h04;
    localparam logic [7:0] CICD_SHIFT_OFS  = 8'h08;
    localparam logic [7:0] CICD_STATUS_OFS = 8'h0C;

    // Field positions
    localparam int CICD_ORDER_LSB    = 0;     // Stage count, 3 bits
    localparam int CICD_ORDER_W      = 3;
    localparam int CICD_BYPASS_BIT   = 15;    // Filter bypass
    localparam int CICD_FEXP_EN_BIT  = 16;    // Add input exponent
    localparam int CICD_REXP_EN_BIT  = 17;    // Add range-control exponent
    localparam int CICD_PRESHIFT_LSB = 20;    // Shift code, bits 25:20
    localparam int CICD_DECIM_LSB    = 0;     // Decimation factor minus one
    localparam int CICD_PHASE_LSB    = 0;     // Status: decimation phase
    localparam int CICD_OUTCNT_LSB   = 16;    // Status: output sample count

    // Reset values
    localparam logic [2:0]  CICD_ORDER_RST    = 3'h5;
    localparam logic [15:0] CICD_DECIM_RST    = 16'h0000;
    localparam logic [5:0]  CICD_PRESHIFT_RST = 6'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [CICD_SAMPLE_W-1:0] i;          // In-phase sample
        logic [CICD_SAMPLE_W-1:0] q;          // Quadrature sample
        logic [CICD_EXP_W-1:0]    exponent;   // Floating-point exponent
    } cicd_in_s;

    typedef struct packed {
        logic [CICD_SAMPLE_W-1:0] i;          // In-phase result
        logic [CICD_SAMPLE_W-1:0] q;          // Quadrature result
    } cicd_iq_s;

endpackage

// ---- rtl/cicd_comb.sv ----
// Purpose: Chain of comb differentiators run at the decimated rate
// Assumes: Strobe marks one decimated sample; order below STAGES+1
// Notes:   Stages beyond the programmed order pass data straight through
`timescale 1ns/1ps
module cicd_comb #(
    parameter int W      = 24,
    parameter int STAGES = 5
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clear,
    input  wire logic         strobe,
    input  wire logic [2:0]   order,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import cicd_pkg::*;

    // Elaboration check on stage count
    if (STAGES < 1 || STAGES > 7) begin : g_bad_stages
        $error("cicd_comb: STAGES out of range");
    end

    logic [W-1:0] x     [STAGES+1];           // Stage inputs, last is output
    logic [W-1:0] prev_q [STAGES];            // One decimated sample delay

    assign x[0] = din;
    assign dout = x[STAGES];

    ////////////////////////////////////////////////////////////////////////////
    for (genvar k = 0; k < STAGES; k++) begin : g_stage
        wire stage_on = (3'(k) < order);      // Stage in use
        assign x[k+1] = stage_on ? (x[k] - prev_q[k]) : x[k];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                prev_q[k] <= '0;
            end else if (clear) begin
                prev_q[k] <= '0;
            end else if (strobe) begin
                prev_q[k] <= x[k];
            end
        end
    end

endmodule

// ---- rtl/cicd_top.sv ----
// Purpose: Pre-shift attenuator and integrator-comb decimator, I and Q
// Assumes: Samples and attenuator word synchronous to pclk; APB slave
// Notes:   Zero-wait APB; writes to control or decimation restart filter
//          Combs see only the top 24 bits of the last active integrator, or of the shifter at order zero
//          No overflow guard on shifter or integrators
`timescale 1ns/1ps
module cicd_top #(
    parameter int DECIM_W = 16,               // Decimation counter width
    parameter int ATTEN_W = 8                 // Attenuator control word width
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   in_valid,
    input  wire cicd_pkg::cicd_in_s     in_sample,
    input  wire logic [ATTEN_W-1:0]     atten_ctrl,
    output logic                        out_valid,
    output cicd_pkg::cicd_iq_s          out_sample
);
    import cicd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // Phase reads back in a 16-bit status field
    if (DECIM_W < 1 || DECIM_W > 16) begin : g_bad_decim
        $error("cicd_top: DECIM_W must be 1 to 16");
    end
    // Range exponent is cut from the top bits
    if (ATTEN_W < CICD_RANGE_W) begin : g_bad_atten
        $error("cicd_top: ATTEN_W narrower than range exponent");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    // Software view, all reset by presetn; cleared except order_q, which loads five
    logic [2:0]              order_q;         // Stage pairs in use
    logic                    bypass_q;        // Filter bypassed
    logic                    fexp_en_q;       // Add input exponent
    logic                    rexp_en_q;       // Add range exponent
    logic [DECIM_W-1:0]      decim_q;         // Decimation factor minus one
    logic [CICD_SHIFT_W-1:0] preshift_q;      // preshift_amount field
    logic [31:0]             prdata_q;        // Read data holding flop
    logic                    clear_q;         // Restart pulse after a control or decimation write

    // Data path state
    // One flop stage sits before the integrators
    logic                    sh_vld_q;        // Shifted sample present
    logic [CICD_BUS_W-1:0]   sh_q [2];        // Shifted bus, per lane
    logic [DECIM_W-1:0]      phase_q;         // Input count within R
    logic                    dec_stb_q;       // Decimated sample ready
    logic                    out_valid_q;     // Output strobe
    cicd_iq_s                out_q;           // Output sample
    logic [CICD_COUNT_W-1:0] out_cnt_q;       // Produced sample count

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    // Phases of one transfer
    wire access   = psel & penable;           // Access phase
    wire setup    = psel & ~penable;          // Setup phase
    // Full byte compare, no aliases
    wire hit_ctrl = (paddr == CICD_CTRL_OFS);
    wire hit_dec  = (paddr == CICD_DECIM_OFS);
    wire hit_sh   = (paddr == CICD_SHIFT_OFS);
    wire hit_stat = (paddr == CICD_STATUS_OFS);
    wire hit_any  = hit_ctrl | hit_dec | hit_sh | hit_stat;
    // Writes land at the access edge
    wire wr_ctrl  = access & pwrite & hit_ctrl;
    wire wr_dec   = access & pwrite & hit_dec;
    wire wr_sh    = access & pwrite & hit_sh;

    // Status writes are dropped, no error
    // Never stalls; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;
    assign prdata  = prdata_q;

    // Refused values fold to the top
    // clamp order to five
    wire [2:0] wr_order = pwdata[CICD_ORDER_LSB +: CICD_ORDER_W];
    wire [2:0] order_in = (wr_order > 3'(CICD_MAX_STAGES)) ? 3'(CICD_MAX_STAGES)
                                                           : wr_order;

    // Read views of each register
    // Unused bits read as zero
    wire [31:0] rd_ctrl = (32'(order_q) << CICD_ORDER_LSB)
                        | (32'(bypass_q) << CICD_BYPASS_BIT)
                        | (32'(fexp_en_q) << CICD_FEXP_EN_BIT)
                        | (32'(rexp_en_q) << CICD_REXP_EN_BIT);
    wire [31:0] rd_dec  = 32'(decim_q) << CICD_DECIM_LSB;
    wire [31:0] rd_sh   = 32'(preshift_q) << CICD_PRESHIFT_LSB;
    wire [31:0] rd_stat = (32'(phase_q) << CICD_PHASE_LSB)
                        | (32'(out_cnt_q) << CICD_OUTCNT_LSB);
    wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                          hit_dec  ? rd_dec  :
                          hit_sh   ? rd_sh   :
                          hit_stat ? rd_stat : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Five stages, filter in path
            order_q   <= CICD_ORDER_RST;
            bypass_q  <= 1'b0;
            fexp_en_q <= 1'b0;
            rexp_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            // Fields land together
            order_q   <= order_in;
            bypass_q  <= pwdata[CICD_BYPASS_BIT];
            fexp_en_q <= pwdata[CICD_FEXP_EN_BIT];
            rexp_en_q <= pwdata[CICD_REXP_EN_BIT];
        end
    end

    // Decimation and shift code writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decim_q    <= DECIM_W'(CICD_DECIM_RST);
            preshift_q <= CICD_PRESHIFT_RST;
        end else begin
            // Stored as R minus one
            if (wr_dec) begin
                decim_q <= pwdata[CICD_DECIM_LSB +: DECIM_W];
            end
            if (wr_sh) begin
                preshift_q <= pwdata[CICD_PRESHIFT_LSB +: CICD_SHIFT_W];
            end
        end
    end

    // Read data captured in setup, stable through access
    // Keeps the decode mux off prdata
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup & ~pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // Restart after order or decimation change; stale sums would be garbage
    // One cycle late so new settings apply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_q <= 1'b0;
        end else begin
            clear_q <= wr_ctrl | wr_dec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift total
    // three MSBs of attenuator word
    wire [CICD_RANGE_W-1:0] range_exp = atten_ctrl[ATTEN_W-1 -: CICD_RANGE_W];
    wire [CICD_EXP_W-1:0]   input_exp = in_sample.exponent;

    // Seven bits hold the largest sum
    // No saturation; software bounds it
    // exponents add to code
    wire [CICD_TOTAL_SHIFT_W-1:0] shift_total =
          CICD_TOTAL_SHIFT_W'(preshift_q)
        + (fexp_en_q ? CICD_TOTAL_SHIFT_W'(input_exp) : CICD_TOTAL_SHIFT_W'(0))
        + (rexp_en_q ? CICD_TOTAL_SHIFT_W'(range_exp) : CICD_TOTAL_SHIFT_W'(0));

    // Sample strobe follows the input by one cycle
    // Lines up with the shifter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_vld_q <= 1'b0;
        end else begin
            sh_vld_q <= in_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decimation phase: one comb sample per R shifted samples
    // Counts accepted samples only
    wire last_phase = (phase_q == decim_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q   <= '0;
            dec_stb_q <= 1'b0;
        // Bypass parks the phase and strobe
        end else if (clear_q || bypass_q) begin
            phase_q   <= '0;
            dec_stb_q <= 1'b0;
        end else begin
            // Strobe on the R-th sample
            dec_stb_q <= sh_vld_q & last_phase;
            if (sh_vld_q) begin
                phase_q <= last_phase ? '0 : phase_q + DECIM_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-lane data path: lane 0 in-phase, lane 1 quadrature
    // Lanes share the shift total and strobes
    logic [CICD_COMB_W-1:0] comb_out [2];     // Comb chain results

    for (genvar ln = 0; ln < 2; ln++) begin : g_lane
        wire [CICD_SAMPLE_W-1:0] raw = (ln == 0) ? in_sample.i : in_sample.q;

        wire [CICD_BUS_W-1:0] ext = {{(CICD_BUS_W-CICD_SAMPLE_W){raw[CICD_SAMPLE_W-1]}},
                                     raw};

        // Shift above 68 clears the lane
        // left barrel shift
        wire [CICD_BUS_W-1:0] shifted = ext << shift_total;

        // Shifter output register
        // Holds between samples
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sh_q[ln] <= '0;
            end else if (in_valid) begin
                sh_q[ln] <= shifted;
            end
        end

        // Integrators held MSB aligned; low bits below each width stay zero
        // Pipelined: each stage adds the old sum
        // Wrap is harmless, combs undo it
        logic [CICD_BUS_W-1:0] acc_q [CICD_MAX_STAGES];

        for (genvar k = 0; k < CICD_MAX_STAGES; k++) begin : g_int
            localparam logic [CICD_BUS_W-1:0] MASK =
                {CICD_BUS_W{1'b1}} << (CICD_BUS_W - CICD_INT_W[k]);
            logic [CICD_BUS_W-1:0] stage_in;  // Addend for this stage
            // Stage one takes the shifter
            if (k == 0) begin : g_head
                assign stage_in = sh_q[ln];
            end else begin : g_tail
                assign stage_in = acc_q[k-1];
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    acc_q[k] <= '0;
                end else if (clear_q) begin
                    acc_q[k] <= '0;
                end else if (sh_vld_q) begin
                    acc_q[k] <= (acc_q[k] + stage_in) & MASK;
                end
            end
        end

        // Order zero feeds the bus straight on
        // pick last active integrator
        wire [CICD_BUS_W-1:0] int_sel = (order_q == 3'h0) ? sh_q[ln]
                                                         : acc_q[order_q - 3'h1];
        wire [CICD_COMB_W-1:0] comb_in = int_sel[CICD_BUS_W-1 -: CICD_COMB_W];

        // Comb chain at the decimated rate
        // Combs move on the strobe only
        cicd_comb #(
            .W      (CICD_COMB_W),
            .STAGES (CICD_MAX_STAGES)
        ) u_comb (
            .pclk    (pclk),
            .presetn (presetn),
            .clear   (clear_q),
            .strobe  (dec_stb_q),
            .order   (order_q),
            .din     (comb_in),
            .dout    (comb_out[ln])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output selection
    // Never both at once: take_filt needs bypass_q low
    // bypass passes top 24 bits
    wire [CICD_SAMPLE_W-1:0] byp_i = sh_q[0][CICD_BUS_W-1 -: CICD_SAMPLE_W];
    wire [CICD_SAMPLE_W-1:0] byp_q = sh_q[1][CICD_BUS_W-1 -: CICD_SAMPLE_W];
    wire                     take_byp  = bypass_q & sh_vld_q;
    wire                     take_filt = ~bypass_q & dec_stb_q;

    // Output register, strobe is a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_q <= 1'b0;
            out_q       <= '0;
        end else begin
            // Data holds until the next strobe
            out_valid_q <= take_byp | take_filt;
            if (take_byp) begin
                out_q.i <= byp_i;
                out_q.q <= byp_q;
            end else if (take_filt) begin
                out_q.i <= comb_out[0];
                out_q.q <= comb_out[1];
            end
        end
    end

    // Produced sample count for software, wraps silently
    // Read back through the status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_cnt_q <= '0;
        end else if (out_valid_q) begin
            out_cnt_q <= out_cnt_q + CICD_COUNT_W'(1);
        end
    end

    // Ports come straight from flops
    assign out_valid  = out_valid_q;
    assign out_sample = out_q;

endmodule

// ---- tb/cicd_props.sv ----
// Purpose: Port checker for the decimator top
// Assumes: Zero-wait APB; control writes are shadowed here
// Notes:   Stream checks wait for a restart to drain
`timescale 1ns/1ps
module cicd_props import cicd_pkg::*; #(
    parameter int DECIM_W = 16,
    parameter int ATTEN_W = 8
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               in_valid,
    input wire cicd_pkg::cicd_in_s in_sample,
    input wire logic [ATTEN_W-1:0] atten_ctrl,
    input wire logic               out_valid,
    input wire cicd_pkg::cicd_iq_s out_sample
);
    // Bypass result: extend, shift, keep the top 24 bits
    function automatic logic [23:0] sh24(input logic [23:0] x, input logic [6:0] s);
        logic [68:0] w;
        w = {{45{x[23]}}, x} << s;
        return w[68:45];
    endfunction
    ////////////////////////////////////////
    logic [17:15] ctl_q;   // Bypass and exponent enables
    logic [5:0]   shf_q;   // Shift code
    logic         dnz_q;   // Decimation above one
    logic [2:0]   quiet_q; // Cycles since restart, saturating
    wire wr_w = psel & penable & pwrite & pready;
    wire rs_w = wr_w & (paddr == CICD_CTRL_OFS | paddr == CICD_DECIM_OFS);
    wire rd_w = psel & penable & !pwrite & paddr == CICD_CTRL_OFS;
    wire qt_w = quiet_q == 3'h7;
    wire [6:0] tot_w = 7'(shf_q) + (ctl_q[16] ? 7'(in_sample.exponent) : 7'h00)
                     + (ctl_q[17] ? 7'(atten_ctrl[ATTEN_W-1 -: 3]) : 7'h00);
    wire [23:0] ei_w = sh24(in_sample.i, tot_w);
    wire [23:0] eq_w = sh24(in_sample.q, tot_w);
    // Shadow registers; a restart makes the stream checks wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 3'h0;
            shf_q <= 6'h00;
            dnz_q <= 1'b0;
            quiet_q <= 3'h7;
        end else begin
            if (wr_w & paddr == CICD_CTRL_OFS) ctl_q <= pwdata[17:15];
            if (wr_w & paddr == CICD_SHIFT_OFS) shf_q <= pwdata[25:20];
            if (wr_w & paddr == CICD_DECIM_OFS) dnz_q <= |pwdata[DECIM_W-1:0];
            quiet_q <= rs_w ? 3'h0 : (qt_w ? 3'h7 : quiet_q + 3'h1);
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_bypass_rate: assert property (in_valid & ctl_q[15] & qt_w |-> ##2 (out_valid | !qt_w))
        else $error("bypass output missing");
    a_bypass_ilane: assert property (out_valid & ctl_q[15] & qt_w
        |-> $past(in_valid, 2) && out_sample.i == $past(ei_w, 2)) else $error("bypass i wrong");
    a_bypass_qlane: assert property (out_valid & ctl_q[15] & qt_w
        |-> out_sample.q == $past(eq_w, 2)) else $error("bypass q wrong");
    a_filter_latency: assert property (out_valid & !ctl_q[15] & qt_w |-> $past(in_valid, 3))
        else $error("filter output without input");
    a_decim_spacing: assert property (out_valid & !ctl_q[15] & dnz_q & qt_w |=> !out_valid)
        else $error("outputs too close");
    a_output_hold: assert property ($changed(out_sample) |-> out_valid)
        else $error("output moved without strobe");
    a_order_limit: assert property (rd_w |-> prdata[2:0] <= 3'h5)
        else $error("order above five");
    a_bypass_read: assert property (rd_w |-> prdata[15] == ctl_q[15])
        else $error("bypass bit readback");
    c_bypass: cover property (out_valid & ctl_q[15] & qt_w);
    c_filter: cover property (out_valid & !ctl_q[15] & dnz_q);
    c_unmapped: cover property (psel & penable & pslverr);
endmodule
bind cicd_top cicd_props #(.DECIM_W(DECIM_W), .ATTEN_W(ATTEN_W)) u_cicd_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_sample(in_sample), .atten_ctrl(atten_ctrl),
    .out_valid(out_valid), .out_sample(out_sample));

// ---- tb/cicd_far_end.sv ----
// Purpose: Mixer source and downstream filter capture
// Assumes: Bench calls stream; one sample per valid edge
// Notes:   Idle data is inverted so stale values never match
`timescale 1ns/1ps
module cicd_far_end #(
    parameter int ATTEN_W = 8
) (
    input  wire logic               pclk,
    input  wire logic               out_valid,
    input  wire cicd_pkg::cicd_iq_s out_sample,
    output logic                    in_valid,
    output cicd_pkg::cicd_in_s      in_sample,
    output logic [ATTEN_W-1:0]      atten_ctrl
);
    import cicd_pkg::*;
    int n_out; // Outputs since the last burst
    initial begin
        in_valid = 1'b0;
        in_sample = '0;
        atten_ctrl = '0;
        n_out = 0;
    end
    // Downstream side only counts; the bench reads the held value
    always @(posedge pclk) begin
        if (out_valid === 1'b1) begin
            n_out <= n_out + 1;
        end
    end
    // Burst of n equal samples, gap idle cycles after each
    task automatic stream(input logic [23:0] xi, xq, input logic [2:0] e,
                          input logic [ATTEN_W-1:0] a, input int n, gap);
        n_out = 0;
        for (int k = 0; k < n; k++) begin
            @(posedge pclk);
            in_valid <= 1'b1;
            in_sample <= '{i: xi, q: xq, exponent: e};
            atten_ctrl <= a;
            repeat (gap) begin
                @(posedge pclk);
                in_valid <= 1'b0;
                in_sample <= ~{xi, xq, e};
            end
        end
        @(posedge pclk);
        in_valid <= 1'b0;
        in_sample <= ~{xi, xq, e};
    endtask
endmodule

// ---- tb/cicd_top_tb.sv ----
// Purpose: Self-checking bench for the decimator top
// Assumes: Zero-wait APB slave; far end drives the stream
// Notes:   Outside the bypass sweep, shift codes are picked so outputs equal inputs
`timescale 1ns/1ps
module cicd_top_tb import cicd_pkg::*;;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, in_valid, out_valid;
    logic [7:0]  atten_ctrl;
    cicd_in_s    in_sample;
    cicd_iq_s    out_sample;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          shf [4] = '{0, 20, 45, 47}; // Low, mid, unity and overflowing shifts
    localparam logic [23:0] XI = 24'hA5C317;
    localparam logic [23:0] XQ = 24'h352E91;
    always #50 pclk = ~pclk;
    cicd_top u_cicd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_sample(in_sample),
        .atten_ctrl(atten_ctrl), .out_valid(out_valid), .out_sample(out_sample));
    cicd_far_end u_cicd_far_end (.pclk(pclk), .out_valid(out_valid), .out_sample(out_sample),
        .in_valid(in_valid), .in_sample(in_sample), .atten_ctrl(atten_ctrl));
    ////////////////////////////////////////
    function automatic logic [23:0] bexp(input logic [23:0] x, input int s);
        logic [68:0] w;
        w = {{45{x[23]}}, x} << s;
        return w[68:45];
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) n_fail++;
        if (k == 20) close_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_out(input int n);
        int k;
        for (k = 0; k < 60 && u_cicd_far_end.n_out != n; k++) @(posedge pclk);
        if (k == 60) n_fail++;
        if (k == 60) close_out();
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        close_out();
    end
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CICD_CTRL_OFS, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, CICD_SHIFT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk(32'(err), 32'h1);
        apb(1'b1, CICD_CTRL_OFS, 32'h7);
        apb(1'b0, CICD_CTRL_OFS, 32'h0);
        chk(rd & 32'h7, 32'h5);
        $display("test registers done");
        // Bypass at four shifts, lost MSBs included
        apb(1'b1, CICD_CTRL_OFS, 32'h0000_8000);
        apb(1'b0, CICD_CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_8000);
        foreach (shf[j]) begin
            apb(1'b1, CICD_SHIFT_OFS, 32'(shf[j]) << 20);
            u_cicd_far_end.stream(XI, XQ, 3'h0, 8'h00, 1, 0);
            wait_out(1);
            chk(32'(out_sample.i), 32'(bexp(XI, shf[j])));
            chk(32'(out_sample.q), 32'(bexp(XQ, shf[j])));
        end
        $display("test bypass done");
        // shift is 45 less the exponent sum of five
        apb(1'b1, CICD_CTRL_OFS, 32'h0003_8000);
        apb(1'b1, CICD_SHIFT_OFS, 32'(40) << 20);
        u_cicd_far_end.stream(XI, XQ, 3'h2, 8'h60, 3, 2);
        wait_out(3);
        chk(32'(out_sample.i), 32'(XI));
        chk(32'(out_sample.q), 32'(XQ));
        $display("test exponents done");
        for (int n = 0; n <= 5; n++) begin
            apb(1'b1, CICD_CTRL_OFS, 32'(n));
            // decimate by two, no exponent, shift 45 less N
            apb(1'b1, CICD_DECIM_OFS, 32'h1);
            apb(1'b1, CICD_SHIFT_OFS, 32'(45 - n) << 20);
            u_cicd_far_end.stream(24'h000120, 24'hFFFEE0, 3'h0, 8'h00, 16, 0);
            wait_out(8);
            repeat (5) @(posedge pclk);
            chk(32'(u_cicd_far_end.n_out), 32'h8);
            chk(32'(out_sample.i), 32'h120);
            chk(32'(out_sample.q), 32'hFFFEE0);
        end
        apb(1'b0, CICD_STATUS_OFS, 32'h0);
        chk(rd, 32'h0037_0000);
        $display("test filter orders done");
        close_out();
    end
endmodule
